//--- logic/sfsp_defs.svh
// Constants of the serial flash status and protection block.
`ifndef SFSP_DEFS_SVH
`define SFSP_DEFS_SVH
`define SFSP_CMD_WRITE_ENABLE  8'h06
`define SFSP_CMD_WRITE_DISABLE 8'h04
`define SFSP_CMD_READ_IDENT    8'h9f
`define SFSP_CMD_READ_STATUS   8'h05
`define SFSP_CMD_WRITE_STATUS  8'h01
`define SFSP_BIT_BUSY        0
`define SFSP_BIT_LATCH       1
`define SFSP_BIT_LVL_LO      2
`define SFSP_BIT_LVL_HI      3
`define SFSP_BIT_LOCK        7
`define SFSP_LVL_RESET       2'h0
`define SFSP_LOCK_RESET      1'b0
`define SFSP_STATUS_WRITE_NS     5000000
`define SFSP_CLK_NS              20
`define SFSP_STATUS_WRITE_CYCLES ((`SFSP_STATUS_WRITE_NS) / (`SFSP_CLK_NS))
`define SFSP_ID_BITS         24
`endif

//--- logic/sfsp_pkg.sv
// Types of the serial flash status and protection block.
package sfsp_pkg;
    typedef enum logic [1:0]
    {
        SFSP_IDLE  = 2'b00,
        SFSP_WCYC  = 2'b01,
        SFSP_EXTB  = 2'b10
    } sfsp_core_st_t;
endpackage

//--- logic/sfsp_top.sv
// Status register, write latch and write protection of a serial flash.
`timescale 1ns/10ps
`include "sfsp_defs.svh"
module sfsp_top #(
    parameter int unsigned  WRITE_CYCLES = `SFSP_STATUS_WRITE_CYCLES,
    // Arbitrary identification value; each product supplies its own.
    parameter logic [23:0]  IDENT_CODE   = 24'h5a_a5_3c,
    parameter logic [7:0]   REGION_MAP   = 8'he4
)(
    // Core clock and reset
    input  wire logic  CORE_CLK,
    input  wire logic  RST_N,
    // Serial link from the host
    input  wire logic  SCLK,
    input  wire logic  CS_N,
    input  wire logic  SI,
    output logic       SO,
    output logic       SO_OE,
    // Protect pin
    input  wire logic  WP_N,
    // Array engine status and requests
    input  wire logic  ARRAY_BUSY,
    input  wire logic  ARRAY_DONE,
    output logic [7:0] STATUS,
    output logic [1:0] REGION,
    output logic       HW_PROTECTED
);
    // ==================================================
    // Link side
    // Everything here runs on SCLK, which stops between frames; each frame
    // leaves latched bytes and a frame summary that the core domain reads once it has synced the select rise.
    logic [2:0]  bit_cnt_q;
    logic [7:0]  sh_q;
    logic [7:0]  cmd_q;
    logic        cmd_ok_q;
    logic [7:0]  data_q;
    logic [4:0]  bytes_q;
    logic        bnd_q;
    logic [4:0]  fend_bytes_q;
    logic [4:0]  out_idx_q;
    logic        so_q;
    logic        so_oe_q;
    logic        busy_lk1_q, busy_lk2_q;
    logic [7:0]  st_lk1_q, st_lk2_q;
    logic [7:0]  stat_core_q;
    logic        busy_core;
    logic        cs_rst_n;
    logic [7:0]  sh_d;

    assign cs_rst_n = RST_N & ~CS_N;
    assign sh_d     = {sh_q[6:0], SI};

    // Status is quasi-static; it is resampled twice on the link clock.
    // Busy comes from the registered byte so no combinational glitch is caught.
    always_ff @(posedge SCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            busy_lk1_q <= 1'b0;
            busy_lk2_q <= 1'b0;
            st_lk1_q   <= 8'h00;
            st_lk2_q   <= 8'h00;
        end
        else
        begin
            busy_lk1_q <= stat_core_q[`SFSP_BIT_BUSY];
            busy_lk2_q <= busy_lk1_q;
            st_lk1_q   <= stat_core_q;
            st_lk2_q   <= st_lk1_q;
        end
    end

    // Input shifting on rising clock; select high resets the frame.
    always_ff @(posedge SCLK or negedge cs_rst_n)
    begin
        if (!cs_rst_n)
        begin
            bit_cnt_q <= 3'h0;
            sh_q      <= 8'h00;
            bytes_q   <= 5'h00;
        end
        else
        begin
            sh_q      <= sh_d;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7 && bytes_q != 5'h1f)
                bytes_q <= bytes_q + 5'h01;
        end
    end

    // Frame length and boundary as of the last clock edge; unlike bytes_q they
    // survive the select rise, so the core can still judge the frame after it.
    always_ff @(posedge SCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            fend_bytes_q <= 5'h00;
            bnd_q        <= 1'b0;
        end
        else
        begin
            bnd_q <= (bit_cnt_q == 3'h7);
            if (bit_cnt_q == 3'h7 && bytes_q != 5'h1f)
                fend_bytes_q <= bytes_q + 5'h01;
            else
                fend_bytes_q <= bytes_q;
        end
    end

    // Command and data byte capture, held after select rises for the core.
    always_ff @(posedge SCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cmd_q    <= 8'h00;
            data_q   <= 8'h00;
            cmd_ok_q <= 1'b0;
        end
        else if (bit_cnt_q == 3'h7)
        begin
            if (bytes_q == 5'h00)
            begin
                cmd_q    <= sh_d;
                cmd_ok_q <= 1'b1;
            end
            else if (bytes_q == 5'h01)
                data_q <= sh_d;
        end
        else if (bytes_q == 5'h00 && bit_cnt_q == 3'h0)
            cmd_ok_q <= 1'b0;
    end

    // Output on falling clock; select high stops driving at once.
    always_ff @(negedge SCLK or negedge cs_rst_n)
    begin
        if (!cs_rst_n)
        begin
            so_q      <= 1'b0;
            so_oe_q   <= 1'b0;
            out_idx_q <= 5'h00;
        end
        else if (bytes_q != 5'h00)
        begin
            if (cmd_q == `SFSP_CMD_READ_IDENT && !busy_lk2_q)
            begin
                // The index stops after the last bit, so the pin is released
                // instead of repeating the code once the index wraps.
                if (out_idx_q < 5'(`SFSP_ID_BITS))
                begin
                    so_oe_q   <= 1'b1;
                    so_q      <= IDENT_CODE[5'd23 - out_idx_q];
                    out_idx_q <= out_idx_q + 5'h01;
                end
                else
                    so_oe_q <= 1'b0;
            end
            else if (cmd_q == `SFSP_CMD_READ_STATUS)
            begin
                so_oe_q   <= 1'b1;
                so_q      <= st_lk2_q[3'h7 - out_idx_q[2:0]];
                out_idx_q <= out_idx_q + 5'h01;
            end
        end
    end

    assign SO    = so_q;
    assign SO_OE = so_oe_q;

    // ==================================================
    // Frame end crossing
    // A select rise is caught on the core clock via a two-stage sync of CS_N.
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic frame_end;
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end
        else
        begin
            cs_s1_q <= CS_N;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end
    assign frame_end = cs_s2_q & ~cs_s3_q;

    logic wp_s1_q, wp_s2_q, ab_s1_q, ab_s2_q, ad_s1_q, ad_s2_q, ad_s3_q;
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
            ab_s1_q <= 1'b0;
            ab_s2_q <= 1'b0;
            ad_s1_q <= 1'b0;
            ad_s2_q <= 1'b0;
            ad_s3_q <= 1'b0;
        end
        else
        begin
            wp_s1_q <= WP_N;
            wp_s2_q <= wp_s1_q;
            ab_s1_q <= ARRAY_BUSY;
            ab_s2_q <= ab_s1_q;
            ad_s1_q <= ARRAY_DONE;
            ad_s2_q <= ad_s1_q;
            ad_s3_q <= ad_s2_q;
        end
    end

    // ==================================================
    // Core status logic
    sfsp_pkg::sfsp_core_st_t st_q;
    logic        latch_q;
    logic [1:0]  lvl_q;
    logic        lock_q;
    logic [1:0]  lvl_new_q;
    logic        lock_new_q;
    logic [31:0] wcyc_cnt_q;
    logic        hw_lock;
    logic        wr_ok;
    logic        is_wr_enable, is_wr_disable, is_wr_status;
    logic        array_done;

    assign hw_lock    = lock_q & ~wp_s2_q;
    assign busy_core  = (st_q == sfsp_pkg::SFSP_WCYC) | ab_s2_q;
    assign array_done = ad_s2_q & ~ad_s3_q;
    // The frame summary is reset by RST_N only, so it still stands at the sync edge.
    assign is_wr_enable  = cmd_ok_q && fend_bytes_q == 5'h01 && bnd_q && cmd_q == `SFSP_CMD_WRITE_ENABLE;
    assign is_wr_disable = cmd_ok_q && fend_bytes_q == 5'h01 && bnd_q && cmd_q == `SFSP_CMD_WRITE_DISABLE;
    assign is_wr_status  = cmd_ok_q && fend_bytes_q == 5'h02 && bnd_q && cmd_q == `SFSP_CMD_WRITE_STATUS;
    assign wr_ok      = latch_q & ~hw_lock & ~busy_core;

    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_q       <= sfsp_pkg::SFSP_IDLE;
            latch_q    <= 1'b0;
            lvl_q      <= `SFSP_LVL_RESET;
            lock_q     <= `SFSP_LOCK_RESET;
            lvl_new_q  <= 2'h0;
            lock_new_q <= 1'b0;
            wcyc_cnt_q <= 32'h0;
        end
        else
        begin
            case (st_q)
                sfsp_pkg::SFSP_IDLE:
                begin
                    if (array_done)
                        latch_q <= 1'b0;
                    else if (frame_end && is_wr_enable && !busy_core)
                        latch_q <= 1'b1;
                    else if (frame_end && is_wr_disable && !busy_core)
                        latch_q <= 1'b0;
                    else if (frame_end && is_wr_status && wr_ok)
                    begin
                        lvl_new_q  <= data_q[`SFSP_BIT_LVL_HI:`SFSP_BIT_LVL_LO];
                        lock_new_q <= data_q[`SFSP_BIT_LOCK];
                        wcyc_cnt_q <= 32'h0;
                        st_q       <= sfsp_pkg::SFSP_WCYC;
                    end
                end
                sfsp_pkg::SFSP_WCYC:
                begin
                    if (wcyc_cnt_q >= WRITE_CYCLES - 1)
                    begin
                        lvl_q   <= lvl_new_q;
                        lock_q  <= lock_new_q;
                        latch_q <= 1'b0;
                        st_q    <= sfsp_pkg::SFSP_IDLE;
                    end
                    else
                        wcyc_cnt_q <= wcyc_cnt_q + 32'h1;
                end
                default:
                    st_q <= sfsp_pkg::SFSP_IDLE;
            endcase
        end
    end

    // Registered status byte and outputs; bits 6..4 read as zero.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            stat_core_q  <= 8'h00;
            REGION       <= 2'h0;
            HW_PROTECTED <= 1'b0;
        end
        else
        begin
            stat_core_q  <= {lock_q, 3'h0, lvl_q, latch_q, busy_core};
            REGION       <= REGION_MAP[{lvl_q, 1'b0} +: 2];
            HW_PROTECTED <= hw_lock;
        end
    end
    assign STATUS = stat_core_q;

    // ==================================================
    // Checks
    AST_BUSY_IN_CYCLE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        st_q == sfsp_pkg::SFSP_WCYC |=> stat_core_q[0]) else $error("busy low in write cycle");
    AST_LATCH_CLR: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        st_q == sfsp_pkg::SFSP_WCYC && wcyc_cnt_q >= WRITE_CYCLES - 1 |=> !latch_q) else $error("latch kept");
    AST_PROT_REJECT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        st_q == sfsp_pkg::SFSP_IDLE && hw_lock |=> st_q == sfsp_pkg::SFSP_IDLE) else $error("write while locked");
    AST_NO_LATCH: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        st_q == sfsp_pkg::SFSP_IDLE && !latch_q |=> st_q != sfsp_pkg::SFSP_WCYC) else $error("write w/o latch");
    AST_LVL_STABLE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        st_q == sfsp_pkg::SFSP_IDLE |=> $stable(lvl_q) && $stable(lock_q)) else $error("level changed");
    AST_ZERO_BITS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        stat_core_q[6:4] == 3'h0) else $error("reserved bits set");
    AST_PROT_OUT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        lock_q && !wp_s2_q |=> HW_PROTECTED) else $error("protection not flagged");
    AST_PROT_EXIT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        wp_s2_q |=> !HW_PROTECTED) else $error("protection with pin high");
    AST_LATCH_SET: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        st_q == sfsp_pkg::SFSP_IDLE && frame_end && is_wr_enable && !busy_core && !array_done |=> latch_q)
        else $error("latch not set");
    AST_LATCH_DROP: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        st_q == sfsp_pkg::SFSP_IDLE && frame_end && is_wr_disable && !busy_core && !array_done |=> !latch_q)
        else $error("latch not cleared");
    AST_WRITE_START: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        st_q == sfsp_pkg::SFSP_IDLE && frame_end && is_wr_status && wr_ok && !array_done |=> busy_core)
        else $error("status write not started");
endmodule // sfsp_top

//--- bench/sfsp_host.sv
// Behavioural serial-bus host that frames commands towards the status block.
`timescale 1ns/10ps
module sfsp_host
(
    // Serial link towards the device
    output logic      sclk,
    output logic      cs_n,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    logic oe_seen;

    initial
    begin
        sclk    = 1'b0;
        cs_n    = 1'b1;
        si      = 1'b0;
        oe_seen = 1'b0;
    end

    // ==========================================================================
    // Frame task
    // The link clock runs only inside a frame; a released data line shows the inverse level.
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        int i;
        rx      = '0;
        oe_seen = 1'b0;
        cs_n    = 1'b0;
        #6;
        for (i = n - 1; i >= 0; i--)
        begin
            si = tx[i];
            #6 sclk = 1'b1;
            rx      = {rx[30:0], so};
            oe_seen = oe_seen | so_oe;
            #6 sclk = 1'b0;
        end
        #6 cs_n = 1'b1;
        si = ~si;
        #100;
    endtask
endmodule // sfsp_host

//--- bench/sfsp_top_bench.sv
// Self-checking testbench of the serial flash status and protection block.
`timescale 1ns/10ps
module sfsp_top_bench;
    // Arbitrary identification value, chosen for the bench only.
    localparam logic [23:0] ID = 24'h5a_a5_3c;
    logic        core_clk;
    logic        rst_n;
    logic        wp_n;
    logic        array_busy;
    logic        array_done;
    wire logic   sclk;
    wire logic   cs_n;
    wire logic   si;
    wire logic   so;
    wire logic   so_oe;
    wire logic   hw_prot;
    wire [7:0]   status;
    wire [1:0]   region;
    int          n_errors;
    int          total_checks;
    logic [31:0] rx;

    sfsp_top #(.WRITE_CYCLES(20), .IDENT_CODE(ID)) i_dut
    (
        .CORE_CLK(core_clk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so),
        .SO_OE(so_oe), .WP_N(wp_n), .ARRAY_BUSY(array_busy), .ARRAY_DONE(array_done),
        .STATUS(status), .REGION(region), .HW_PROTECTED(hw_prot)
    );
    sfsp_host i_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ==========================================================================
    // Shared tasks
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Leaves the core time to act on the frame before anything is judged.
    task automatic cmd(input int n, input logic [31:0] tx);
        i_host.xfer(n, tx, rx);
        cyc(6);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 200 && status[0] !== 1'b0; i++)
            cyc(1);
        if (i == 200)
        begin
            n_errors++;
            $display("[FAIL] busy wait expected 0 seen 1");
            summarize();
        end
    endtask

    // ==========================================================================
    // Scenarios
    task automatic t_latch();
        chk("reset status", 32'h0, status);
        cmd(8, 32'h06);
        chk("latch set", 32'h02, status);
        cmd(24, 32'h05_0000);
        chk("status twice", 32'h0202, rx[15:0]);
        cmd(9, 32'h009);
        chk("long disable", 32'h02, status);
        cmd(8, 32'h04);
        chk("latch clear", 32'h00, status);
        $display("latch test done");
    endtask

    task automatic t_ident();
        cmd(32, 32'h9f00_0000);
        chk("ident", ID, rx[23:0]);
        chk("so released", 32'h0, so_oe);
        $display("ident test done");
    endtask

    task automatic t_write_status_cmd();
        cmd(8, 32'h06);
        cmd(9, 32'h003);
        chk("short write", 32'h0, status & 8'h8d);
        cmd(16, 32'h01fc);
        chk("busy", 32'h1, status[0]);
        wait_idle();
        chk("written", 32'h8c, status);
        chk("region", 32'h3, region);
        cmd(16, 32'h0100);
        chk("no latch", 32'h8c, status);
        $display("status write test done");
    endtask

    task automatic t_prot();
        @(posedge core_clk);
        wp_n <= 1'b0;
        cyc(5);
        chk("hw prot on", 32'h1, hw_prot);
        cmd(8, 32'h06);
        cmd(16, 32'h0100);
        wait_idle();
        chk("locked refuse", 32'h8c, status & 8'h8d);
        wp_n <= 1'b1;
        cyc(5);
        chk("hw prot off", 32'h0, hw_prot);
        cmd(8, 32'h06);
        cmd(16, 32'h0100);
        wait_idle();
        chk("unlocked", 32'h00, status);
        wp_n <= 1'b0;
        cmd(8, 32'h06);
        cmd(16, 32'h0104);
        wait_idle();
        chk("pin low unlocked", 32'h04, status);
        chk("no hw prot", 32'h0, hw_prot);
        cmd(8, 32'h06);
        cmd(16, 32'h0100);
        wait_idle();
        wp_n <= 1'b1;
        $display("protection test done");
    endtask

    task automatic t_array();
        cmd(8, 32'h06);
        array_busy <= 1'b1;
        cyc(4);
        chk("array busy", 32'h03, status);
        cmd(32, 32'h9f00_0000);
        chk("ident ignored", 32'h0, i_host.oe_seen);
        cmd(16, 32'h0500);
        chk("status while busy", 32'h03, rx[7:0]);
        array_busy <= 1'b0;
        array_done <= 1'b1;
        cyc(6);
        chk("done clears", 32'h00, status);
        array_done <= 1'b0;
        $display("array test done");
    endtask

    initial
    begin
        n_errors     = 0;
        total_checks = 0;
        rst_n        = 1'b0;
        wp_n         = 1'b1;
        array_busy   = 1'b0;
        array_done   = 1'b0;
        cyc(10);
        rst_n <= 1'b1;
        cyc(4);
        t_latch();
        t_ident();
        t_write_status_cmd();
        t_prot();
        t_array();
        summarize();
    end
endmodule // sfsp_top_bench
